// *** core/auto_program_stage_sequencer.sv ***
// automatic program stage sequencer with apb register access
// assumes run_cmd, norm_* and ms_sel_in come from logic on pclk
//
// Contract
// - mode 0 turns sequencing off and the normal reference passes through.
// - modes 1 and 4 run the sequence once; only mode 1 restarts at the stopped speed.
// - modes 2 and 5 repeat the sequence; only mode 2 restarts at the stopped speed.
// - modes 3 and 6 run once then hold the last stage's speed.
// - modes 1 to 3 resume at the unfinished stage after a stop.
// - modes 4 to 6 restart at stage 0 after a stop, except mode 6 stopped while holding, which returns to the hold.
// - stage 0 uses the multi-speed 0 frequency, stages 1 to 15 their own.
// - frequencies span 0 to 400.00 hz, coarsened to 0.1 hz above 300 hz max.
// - each stage has a 0 to 6000.0 s run time that sets its length.
// - stage direction 0 stops, 1 runs forward, 2 runs reverse.
// - wobbling or pid enabled inhibits sequencing.
// - all stage times zero makes sequencing inactive.
// - multi-step speed inputs are ignored while sequencing is enabled.
// - sequencing ramps with the primary accel and decel times.
// - single-cycle mode stops output after the last stage and waits.
// - hold mode keeps the last stage's speed and direction until stopped.
`include "stage_seq_regs.svh"

module auto_program_stage_sequencer #(
   parameter int TICK_CYCLES = `TIME_STEP_NS / `CLK_PERIOD_NS
) (
   input wire logic pclk, // control clock, 10 mhz
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped address
   input wire logic run_cmd, // drive run command level
   input wire logic [15:0] norm_freq, // normal frequency reference
   input wire logic [1:0] norm_dir, // normal direction
   input wire logic [3:0] ms_sel_in, // multi-step speed inputs 1..4
   output logic [15:0] freq_ref, // frequency reference to ramp
   output logic [1:0] dir_ref, // direction to ramp
   output logic run_out, // output enable to ramp
   output logic ramp_primary, // use primary accel/decel
   output logic [3:0] ms_sel_out, // gated multi-step inputs
   output logic [3:0] stage_out, // current stage number
   output logic seq_active // sequencer driving output
);

   localparam int TW = $clog2(TICK_CYCLES + 1);

   // refuse a time base the counter cannot serve
   if (TICK_CYCLES < 1)
   begin : g_bad_tick
      $error("TICK_CYCLES must be at least 1");
   end

   // configuration storage
   logic [31:0] ctrl_q;
   stage_seq_pkg::setting_t freq_q [16];
   stage_seq_pkg::setting_t time_q [16];
   logic [1:0] dcfg_q [16];

   // sequencer state
   stage_seq_pkg::seq_state_e state_q, state_d;
   logic [3:0] stage_q, stage_d;
   stage_seq_pkg::setting_t timer_q, timer_d;
   logic [TW-1:0] tick_q, tick_d;
   logic resume_q, resume_d;

   // output and bus flops
   logic [15:0] freq_ref_q;
   logic [1:0] dir_ref_q;
   logic run_out_q, ramp_primary_q, seq_active_q;
   logic [3:0] ms_sel_q;
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q;

   // bus decode
   wire access = psel & penable;
   wire commit = access & pready_q;
   wire wr_commit = commit & pwrite;
   wire in_freq = paddr >= `SEQ_FREQ_BASE && paddr < `SEQ_TIME_BASE;
   wire in_time = paddr >= `SEQ_TIME_BASE && paddr < `SEQ_DIR_BASE;
   wire in_dir = paddr >= `SEQ_DIR_BASE &&
      paddr < (`SEQ_DIR_BASE + `SEQ_TABLE_SPAN);
   wire is_ctrl = paddr == `SEQ_CTRL_OFF;
   wire is_stat = paddr == `SEQ_STAT_OFF;
   wire aligned = paddr[1:0] == 2'b00;
   wire mapped = aligned & (is_ctrl | is_stat | in_freq | in_time | in_dir);
   wire [3:0] idx = paddr[5:2];

   // write data clamped to the setting ranges
   wire [15:0] wfreq = (pwdata[31:16] != 16'h0000 ||
      pwdata[15:0] > `FREQ_MAX) ? `FREQ_MAX : pwdata[15:0];
   wire [15:0] wtime = (pwdata[31:16] != 16'h0000 ||
      pwdata[15:0] > `TIME_MAX) ? `TIME_MAX : pwdata[15:0];

   // control fields
   wire [2:0] mode = ctrl_q[`CTRL_MODE_LSB +: 3];
   wire wobble_en = ctrl_q[`CTRL_WOBBLE_BIT];
   wire pid_en = ctrl_q[`CTRL_PID_BIT];
   wire coarse = ctrl_q[`CTRL_COARSE_BIT];
   wire mode_valid = mode != 3'h0 && mode <= 3'h6;
   wire mode_once = mode == 3'h1 || mode == 3'h4;
   wire mode_loop = mode == 3'h2 || mode == 3'h5;
   wire mode_hold = mode == 3'h3 || mode == 3'h6;
   wire mode_resume = mode <= 3'h3;

   // any stage time nonzero
   logic any_time;
   always_comb
   begin
      any_time = 1'b0;
      for (int i = 0; i < 16; i++)
      begin
         any_time = any_time | (time_q[i] != `TABLE_RST);
      end
   end

   wire enabled = mode_valid & ~wobble_en & ~pid_en & any_time;

   // stage settings seen by the sequencer
   wire [15:0] stage_freq_raw = freq_q[stage_q];
   wire [15:0] stage_freq = coarse ?
      stage_freq_raw - (stage_freq_raw % `FREQ_COARSE_STEP) :
      stage_freq_raw;
   wire [1:0] stage_dir_raw = dcfg_q[stage_q];
   wire [1:0] stage_dir = (stage_dir_raw == stage_seq_pkg::DIR_FWD ||
      stage_dir_raw == stage_seq_pkg::DIR_REV) ?
      stage_dir_raw : stage_seq_pkg::DIR_STOP;
   wire tick = tick_q == TW'(TICK_CYCLES - 1);
   wire last_stage = stage_q == 4'hf;

   // read data selection
   wire [31:0] stat_word = {22'h0, enabled, dir_ref_q,
      state_q == stage_seq_pkg::ST_HOLD,
      state_q == stage_seq_pkg::ST_DONE, seq_active_q, stage_q};
   wire [31:0] rd_word = is_ctrl ? ctrl_q :
      is_stat ? stat_word :
      in_freq ? {16'h0, freq_q[idx]} :
      in_time ? {16'h0, time_q[idx]} :
      in_dir ? {30'h0, dcfg_q[idx]} : 32'h0;

   // control register write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_q <= `CTRL_RST;
      else if (wr_commit && is_ctrl && aligned)
         ctrl_q <= {26'h0, pwdata[5:0]};
   end

   // per-stage setting tables, stage 0 frequency is multi-speed 0
   for (genvar g = 0; g < 16; g++)
   begin : g_stage
      wire hit = wr_commit && aligned && idx == 4'(g);
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            freq_q[g] <= `TABLE_RST;
            time_q[g] <= `TABLE_RST;
            dcfg_q[g] <= 2'h0;
         end
         else
         begin
            if (hit && in_freq)
               freq_q[g] <= wfreq;
            if (hit && in_time)
               time_q[g] <= wtime;
            if (hit && in_dir)
               dcfg_q[g] <= pwdata[1:0];
         end
      end
   end

   // apb answer: ready one cycle into the access phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end
      else
      begin
         pready_q <= access & ~pready_q;
         pslverr_q <= access & ~pready_q & ~mapped;
         prdata_q <= (access & ~pready_q & ~pwrite & mapped) ?
            rd_word : 32'h0;
      end
   end

   // sequencer next state
   always_comb
   begin
      state_d = state_q;
      stage_d = stage_q;
      timer_d = timer_q;
      tick_d = tick_q;
      resume_d = resume_q;
      if (!enabled)
      begin
         state_d = stage_seq_pkg::ST_IDLE;
         stage_d = 4'h0;
         timer_d = time_q[0];
         tick_d = '0;
         resume_d = 1'b0;
      end
      else
      begin
         case (state_q)
            stage_seq_pkg::ST_IDLE:
            begin
               if (run_cmd)
               begin
                  tick_d = '0;
                  if (resume_q && mode_resume)
                     state_d = stage_seq_pkg::ST_RUN;
                  else if (resume_q && mode_hold && stage_q == 4'hf &&
                     timer_q == `TABLE_RST)
                     state_d = stage_seq_pkg::ST_HOLD;
                  else
                  begin
                     state_d = stage_seq_pkg::ST_RUN;
                     stage_d = 4'h0;
                     timer_d = time_q[0];
                  end
               end
            end
            stage_seq_pkg::ST_RUN:
            begin
               if (!run_cmd)
               begin
                  state_d = stage_seq_pkg::ST_IDLE;
                  resume_d = 1'b1;
               end
               else if (timer_q == `TABLE_RST)
               begin
                  tick_d = '0;
                  if (!last_stage)
                  begin
                     stage_d = stage_q + 4'h1;
                     timer_d = time_q[stage_q + 4'h1];
                  end
                  else if (mode_loop)
                  begin
                     stage_d = 4'h0;
                     timer_d = time_q[0];
                  end
                  else if (mode_hold)
                     state_d = stage_seq_pkg::ST_HOLD;
                  else if (mode_once)
                  begin
                     state_d = stage_seq_pkg::ST_DONE;
                     resume_d = 1'b0;
                  end
               end
               else if (tick)
               begin
                  tick_d = '0;
                  timer_d = timer_q - 16'h0001;
               end
               else
                  tick_d = tick_q + TW'(1);
            end
            stage_seq_pkg::ST_HOLD:
            begin
               if (!run_cmd)
               begin
                  state_d = stage_seq_pkg::ST_IDLE;
                  resume_d = 1'b1;
               end
            end
            stage_seq_pkg::ST_DONE:
            begin
               if (!run_cmd)
                  state_d = stage_seq_pkg::ST_IDLE;
            end
            default:
               state_d = stage_seq_pkg::ST_IDLE;
         endcase
      end
   end

   // sequencer registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= stage_seq_pkg::ST_IDLE;
         stage_q <= 4'h0;
         timer_q <= `TABLE_RST;
         tick_q <= '0;
         resume_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         stage_q <= stage_d;
         timer_q <= timer_d;
         tick_q <= tick_d;
         resume_q <= resume_d;
      end
   end

   // output selection toward the ramp logic
   wire driving = state_q == stage_seq_pkg::ST_RUN ||
      state_q == stage_seq_pkg::ST_HOLD;
   wire [15:0] freq_nx = !enabled ? norm_freq :
      driving ? stage_freq : 16'h0;
   wire [1:0] dir_nx = !enabled ? norm_dir :
      driving ? stage_dir : stage_seq_pkg::DIR_STOP;
   wire run_nx = !enabled ? run_cmd :
      driving && stage_dir != stage_seq_pkg::DIR_STOP;

   // registered outputs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         freq_ref_q <= 16'h0;
         dir_ref_q <= 2'h0;
         run_out_q <= 1'b0;
         ramp_primary_q <= 1'b0;
         ms_sel_q <= 4'h0;
         seq_active_q <= 1'b0;
      end
      else
      begin
         freq_ref_q <= freq_nx;
         dir_ref_q <= dir_nx;
         run_out_q <= run_nx;
         ramp_primary_q <= enabled;
         ms_sel_q <= enabled ? 4'h0 : ms_sel_in;
         seq_active_q <= enabled & driving;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign freq_ref = freq_ref_q;
   assign dir_ref = dir_ref_q;
   assign run_out = run_out_q;
   assign ramp_primary = ramp_primary_q;
   assign ms_sel_out = ms_sel_q;
   assign stage_out = stage_q;
   assign seq_active = seq_active_q;

endmodule // auto_program_stage_sequencer

// *** core/stage_seq_pkg.sv ***
// types shared by the stage sequencer
// assumes stage_seq_regs.svh supplies the numeric constants
package stage_seq_pkg;

   // sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_HOLD = 2'b10,
      ST_DONE = 2'b11
   } seq_state_e;

   // per-stage direction codes
   typedef enum logic [1:0] {
      DIR_STOP = 2'b00,
      DIR_FWD = 2'b01,
      DIR_REV = 2'b10
   } dir_e;

   typedef logic [15:0] setting_t;

endpackage

// *** core/stage_seq_regs.svh ***
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit apb slave with word-aligned byte addresses
`ifndef STAGE_SEQ_REGS_SVH
`define STAGE_SEQ_REGS_SVH

// byte offsets
`define SEQ_CTRL_OFF 12'h000
`define SEQ_STAT_OFF 12'h004
`define SEQ_FREQ_BASE 12'h040
`define SEQ_TIME_BASE 12'h080
`define SEQ_DIR_BASE 12'h0c0
`define SEQ_TABLE_SPAN 12'h040

// control fields
`define CTRL_MODE_LSB 0
`define CTRL_WOBBLE_BIT 3
`define CTRL_PID_BIT 4
`define CTRL_COARSE_BIT 5
`define CTRL_RST 32'h0000_0000

// status fields
`define STAT_STAGE_LSB 0
`define STAT_ACTIVE_BIT 4
`define STAT_DONE_BIT 5
`define STAT_HOLD_BIT 6
`define STAT_DIR_LSB 7
`define STAT_ENABLED_BIT 9

// setting limits: frequency 0.01 hz units, time 0.1 s units
`define FREQ_MAX 16'h9c40
`define TIME_MAX 16'hea60
`define FREQ_COARSE_STEP 16'h000a
`define TABLE_RST 16'h0000

// time base: one time step is 0.1 s, clock period 100 ns
`define TIME_STEP_NS 100000000
`define CLK_PERIOD_NS 100

`endif

// *** verif/auto_program_stage_sequencer_tb.sv ***
// self-checking bench for the stage sequencer
// assumes the monitor bind and ramp model compile alongside
`include "stage_seq_regs.svh"
module auto_program_stage_sequencer_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic run_cmd, run_out, ramp_primary, seq_active;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] norm_freq, freq_ref, mfreq;
   logic [1:0] norm_dir, dir_ref;
   logic [3:0] ms_sel_in, ms_sel_out, stage_out;
   logic [5:0] rows [10];
   int err_count = 0;
   int compares = 0;
   int cyc = 0;
   auto_program_stage_sequencer #(.TICK_CYCLES(4)) dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .run_cmd(run_cmd), .norm_freq(norm_freq),
      .norm_dir(norm_dir), .ms_sel_in(ms_sel_in), .freq_ref(freq_ref),
      .dir_ref(dir_ref), .run_out(run_out), .ramp_primary(ramp_primary),
      .ms_sel_out(ms_sel_out), .stage_out(stage_out),
      .seq_active(seq_active));
   drive_ramp_model ramp (.pclk(pclk), .presetn(presetn),
      .freq_ref(freq_ref), .run_out(run_out),
      .ramp_primary(ramp_primary), .out_freq(mfreq));
   task stop_test;
      $display("compares %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   // one apb transfer, entered just after a rising edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task wt(input logic [3:0] s);
      while (!(seq_active === 1'b1 && stage_out === s)) @(posedge pclk);
   endtask
   task bump;
      run_cmd <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("stopped", seq_active, 0);
      run_cmd <= 1'b1;
      repeat (3) @(posedge pclk);
   endtask
   // clock
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // hang guard
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         err_count++;
         stop_test();
      end
   end
   // main sequence
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, run_cmd} = '0;
      presetn = 1'b0;
      norm_freq = 16'h1234;
      norm_dir = 2'h1;
      ms_sel_in = 4'h5;
      rows = '{6'h00, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h07,
         6'h09, 6'h11};
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, `SEQ_CTRL_OFF, 0);
      chk("ctrl", rd, `CTRL_RST);
      apb(1, `SEQ_CTRL_OFF, 1);
      repeat (3) @(posedge pclk);
      chk("zero times", ramp_primary, 0);
      // stage table: freq, time, direction
      for (int i = 0; i < 16; i++)
      begin
         apb(1, 12'(`SEQ_FREQ_BASE + 4 * i), 32'(155 + 100 * i));
         apb(1, 12'(`SEQ_TIME_BASE + 4 * i), (i < 3 || i == 15) ? 2 : 0);
         apb(1, 12'(`SEQ_DIR_BASE + 4 * i), i < 3 ? 1 : (i == 15 ? 2 : 0));
      end
      apb(1, 12'h044, 32'h0000_c350);
      apb(0, 12'h044, 0);
      chk("clamp", rd, 32'h0000_9c40);
      apb(1, 12'h044, 255);
      apb(0, 12'h100, 0);
      chk("slverr", er, 1);
      foreach (rows[r])
      begin
         apb(1, `SEQ_CTRL_OFF, {27'h0, rows[r][4:0]});
         repeat (3) @(posedge pclk);
         chk("primary", ramp_primary, rows[r][5]);
         chk("ms out", ms_sel_out, rows[r][5] ? 0 : ms_sel_in);
         chk("freq", freq_ref, rows[r][5] ? 0 : norm_freq);
      end
      $display("mode table done");
      apb(1, `SEQ_CTRL_OFF, 1);
      run_cmd <= 1'b1;
      wt(0);
      chk("f0", freq_ref, 155);
      chk("d0", dir_ref, 1);
      wt(1);
      @(posedge pclk); // reference lags the stage number by one clock
      chk("f1", freq_ref, 255);
      wt(15);
      @(posedge pclk); // direction lags the stage number by one clock
      chk("d15", dir_ref, 2);
      while (seq_active === 1'b1) @(posedge pclk);
      repeat (20) @(posedge pclk);
      chk("done", seq_active, 0);
      chk("done run", run_out, 0);
      run_cmd <= 1'b0;
      $display("single cycle done");
      apb(1, `SEQ_CTRL_OFF, 2);
      run_cmd <= 1'b1;
      wt(15);
      while (stage_out === 4'hf) @(posedge pclk);
      chk("wrap act", seq_active, 1);
      chk("wrap", stage_out, 0);
      wt(1);
      bump();
      chk("resume", stage_out, 1);
      chk("resume f", freq_ref, 255);
      apb(1, `SEQ_CTRL_OFF, 5);
      wt(1);
      bump();
      chk("restart", stage_out, 0);
      $display("restart done");
      run_cmd <= 1'b0;
      apb(1, `SEQ_CTRL_OFF, 0);
      apb(1, `SEQ_CTRL_OFF, 32'h23);
      run_cmd <= 1'b1;
      wt(15);
      repeat (150) @(posedge pclk);
      chk("hold", seq_active, 1);
      chk("hold st", stage_out, 15);
      chk("coarse", freq_ref, 1650);
      chk("hold d", dir_ref, 2);
      chk("ramped", mfreq, 1650);
      apb(0, `SEQ_STAT_OFF, 0);
      chk("status", rd, (32'hf << `STAT_STAGE_LSB) |
         (32'h1 << `STAT_ACTIVE_BIT) | (32'h1 << `STAT_HOLD_BIT) |
         (32'h2 << `STAT_DIR_LSB) | (32'h1 << `STAT_ENABLED_BIT));
      run_cmd <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("off", freq_ref, 0);
      $display("hold done");
      // reset in mid-run while holding
      run_cmd <= 1'b1;
      repeat (20) @(posedge pclk);
      chk("pre rst", seq_active, 1);
      presetn <= 1'b0;
      @(posedge pclk);
      chk("rst stage", stage_out, 0);
      chk("rst active", seq_active, 0);
      chk("rst freq", freq_ref, 0);
      chk("rst prim", ramp_primary, 0);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      chk("rst pass", freq_ref, norm_freq);
      chk("rst run", run_out, 1);
      apb(0, `SEQ_CTRL_OFF, 0);
      chk("rst ctrl", rd, `CTRL_RST);
      $display("reset done");
      stop_test();
   end
endmodule // auto_program_stage_sequencer_tb

// *** verif/drive_ramp_model.sv ***
// behavioural ramp generator fed by the sequencer
// assumes steps per cycle stand in for accel and decel times
module drive_ramp_model #(
   parameter int PRI_STEP = 16,
   parameter int MS_STEP = 4
) (
   input wire logic pclk, // clock
   input wire logic presetn, // reset, active low
   input wire logic [15:0] freq_ref, // target
   input wire logic run_out, // output enable
   input wire logic ramp_primary, // primary ramp select
   output logic [15:0] out_freq // ramped output
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] tgt;
   logic [15:0] stp;
   // target and step choice
   assign tgt = run_out ? freq_ref : 16'h0;
   assign stp = ramp_primary ? 16'(PRI_STEP) : 16'(MS_STEP);
   // move toward target by one step a cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         out_freq <= 16'h0;
      else if (out_freq + stp < tgt)
         out_freq <= out_freq + stp;
      else if (out_freq > tgt + stp)
         out_freq <= out_freq - stp;
      else
         out_freq <= tgt;
   end
endmodule // drive_ramp_model

// *** verif/stage_seq_monitor.sv ***
// port assertions for the stage sequencer
// assumes it is bound into auto_program_stage_sequencer
`include "stage_seq_regs.svh"
module stage_seq_monitor (
   input wire logic pclk, // clock
   input wire logic presetn, // reset, active low
   input wire logic run_cmd, // run level
   input wire logic [15:0] norm_freq, // normal reference
   input wire logic [3:0] ms_sel_in, // multi-step in
   input wire logic [15:0] freq_ref, // reference out
   input wire logic [1:0] dir_ref, // direction out
   input wire logic run_out, // run out
   input wire logic ramp_primary, // sequencing enabled
   input wire logic [3:0] ms_sel_out, // gated steps
   input wire logic [3:0] stage_out, // stage number
   input wire logic seq_active // sequencer driving
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] up_q;
   logic ok;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // settle count so $past in p_off and p_gate never sees reset values
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         up_q <= 2'h0;
      else if (!up_q[1])
         up_q <= up_q + 2'h1;
   end
   assign ok = up_q[1];
   // start and stop steps
   sequence s_go;
      ramp_primary && !seq_active && $rose(run_cmd) ##1 run_cmd;
   endsequence
   sequence s_halt;
      seq_active && !run_cmd;
   endsequence
   property p_off;
      ok && !ramp_primary |-> freq_ref == $past(norm_freq)
         && run_out == $past(run_cmd);
   endproperty
   property p_gate;
      ok |-> ms_sel_out == (ramp_primary ? 4'h0 : $past(ms_sel_in));
   endproperty
   property p_prim;
      seq_active |-> ramp_primary;
   endproperty
   property p_dir;
      ramp_primary |-> run_out == (seq_active && dir_ref != 2'h0);
   endproperty
   property p_lim;
      ramp_primary |-> freq_ref <= `FREQ_MAX;
   endproperty
   property p_step;
      seq_active && $past(seq_active) && stage_out != $past(stage_out)
         |-> stage_out == $past(stage_out) + 4'h1;
   endproperty
   property p_idle;
      ramp_primary && !seq_active |-> freq_ref == 16'h0 && !run_out;
   endproperty
   property p_start;
      s_go |-> ##1 seq_active;
   endproperty
   property p_stop;
      s_halt |-> ##2 !seq_active;
   endproperty
   a_off: assert property (p_off) else $error("pass-through wrong");
   a_gate: assert property (p_gate) else $error("ms gate wrong");
   a_prim: assert property (p_prim) else $error("ramp select wrong");
   a_dir: assert property (p_dir) else $error("run vs dir wrong");
   a_lim: assert property (p_lim) else $error("freq above max");
   a_step: assert property (p_step) else $error("stage skipped");
   a_idle: assert property (p_idle) else $error("idle output on");
   a_start: assert property (p_start) else $error("no start");
   a_stop: assert property (p_stop) else $error("no stop");
endmodule // stage_seq_monitor

bind auto_program_stage_sequencer stage_seq_monitor u_mon (
   .pclk(pclk), .presetn(presetn), .run_cmd(run_cmd),
   .norm_freq(norm_freq), .ms_sel_in(ms_sel_in), .freq_ref(freq_ref),
   .dir_ref(dir_ref), .run_out(run_out), .ramp_primary(ramp_primary),
   .ms_sel_out(ms_sel_out), .stage_out(stage_out),
   .seq_active(seq_active));
